/* src/timing_seq_consts.vh */
`ifndef TIMING_SEQ_CONSTS_VH
`define TIMING_SEQ_CONSTS_VH
// ----------------------------------------------------------------
// Clock and tick timing
// ----------------------------------------------------------------
`define CLK_MHZ 10
`define TICK_US 5
`define TICK_CYCLES (`TICK_US * `CLK_MHZ)
// ----------------------------------------------------------------
// Command word field positions
// ----------------------------------------------------------------
`define CW_SIGN_HI 43
`define CW_VAR_HI 27
`define CW_OP_HI 23
`define CW_ADDR_HI 15
`define CW_COUNT_HI 7
// ----------------------------------------------------------------
// Operation codes, two BCD digits
// ----------------------------------------------------------------
`define OPC_INPUT_KEY 8'h03
`define OPC_INPUT_TAPE 8'h05
`define OPC_CLEAR_LOAD 8'h10
`define OPC_ADD 8'h12
`define OPC_SUB 8'h13
`define OPC_PRODUCT 8'h14
`define OPC_ROUND 8'h16
`define OPC_ADD_LOC 8'h19
`define OPC_INC_INDEX_BR 8'h20
`define OPC_DEC_INDEX_BR 8'h21
`define OPC_RECORD_MOVE 8'h29
`define OPC_SHR 8'h48
`define OPC_SHL 8'h49
`define OPC_TAPE_CTL 8'h50
`define OPC_TAPE_XFER 8'h51
`define OPC_TAPE_LO 8'h52
`define OPC_TAPE_HI 8'h58
`define OPC_INPUT_CARD_A 8'h60
`define OPC_INPUT_CARD_B 8'h62
`define OPC_INPUT_CARD_C 8'h64
// ----------------------------------------------------------------
// Durations in microseconds, as printed, then the round threshold and the last word address
// ----------------------------------------------------------------
`define T_MUL_BASE_US 90
`define T_RECORD_BASE_US 130
`define T_RECORD_STEP_US 60
`define T_RECORD_ZERO_US 6130
`define T_SHL_ONE_US 160
`define T_SHL_PAIR_US 210
`define T_SHR_BASE_US 110
`define T_ROUND_LOW_US 105
`define T_ROUND_HIGH_US 165
`define T_SUB_PLAIN_US 185
`define T_SUB_DECOMP_US 245
`define T_ADDLOC_PLAIN_US 255
`define T_ADDLOC_DECOMP_US 315
`define T_INDEX_NOBR_US 130
`define T_INDEX_BR_US 150
`define T_TAPE_SETUP_US 160
`define T_TAPE_CTL_US 195
`define T_TAPE_XFER_US 245
`define T_DEFAULT_US 100
`define ROUND_THRESHOLD 4'h5
`define WORDS_LAST_BCD 16'h5999
`endif

/* src/tick_divider.v */
`timescale 1ns/1ps
`default_nettype none
`include "timing_seq_consts.vh"
module tick_divider (
  input wire core_clk, // Processor clock.
  input wire rst, // Synchronous reset, active high.
  input wire restart, // Restarts the tick period.
  output reg tick // One-cycle pulse every 5 us.
);
  localparam integer LAST_INT = `TICK_CYCLES - 1;
  localparam [5:0] LAST = LAST_INT[5:0];
  reg [5:0] div_reg;

  // Divides the clock down to the duration tick.
  always @(posedge core_clk) begin
    if (rst || restart) begin
      div_reg <= 6'h00;
      tick <= 1'b0;
    end else if (div_reg == LAST) begin
      div_reg <= 6'h00;
      tick <= 1'b1;
    end else begin
      div_reg <= div_reg + 6'h01;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* src/mantissa_normalizer.v */
`timescale 1ns/1ps
`default_nettype none
module mantissa_normalizer (
  input wire core_clk, // Processor clock.
  input wire rst, // Synchronous reset, active high.
  input wire start, // Loads a raw result.
  input wire [31:0] mant_in, // Raw mantissa, eight BCD digits.
  input wire [7:0] exp_in, // Raw exponent.
  output reg [31:0] mant_reg, // Normalized mantissa.
  output reg [7:0] exp_reg, // Adjusted exponent.
  output reg norm_done // One-cycle pulse when finished.
);
  reg busy_reg;

  // Shifts one digit per cycle until the top digit is nonzero.
  always @(posedge core_clk) begin
    if (rst) begin
      mant_reg <= 32'h00000000;
      exp_reg <= 8'h00;
      busy_reg <= 1'b0;
      norm_done <= 1'b0;
    end else if (start) begin
      mant_reg <= mant_in;
      exp_reg <= exp_in;
      busy_reg <= 1'b1;
      norm_done <= 1'b0;
    end else if (busy_reg) begin
      if (mant_reg[31:28] != 4'h0 || mant_reg == 32'h00000000) begin
        busy_reg <= 1'b0;
        norm_done <= 1'b1;
      end else begin
        mant_reg <= {mant_reg[27:0], 4'h0};
        exp_reg <= exp_reg - 8'h01;
      end
    end else begin
      norm_done <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* src/instruction_timing_sequencer.v */
`timescale 1ns/1ps
`default_nettype none
`include "timing_seq_consts.vh"
module instruction_timing_sequencer (
  input wire core_clk, // Processor clock, 10 MHz.
  input wire rst, // Synchronous reset, active high.
  input wire start, // Begins execution of cmd_word.
  input wire [43:0] cmd_word, // Instruction: sign plus ten digits.
  input wire [43:0] store_word, // Word read from storage.
  input wire [39:0] remainder_word, // Remainder word digits.
  input wire decomp, // Result needs decomplementing.
  input wire tape_ready, // Tape unit ready.
  input wire [15:0] index_before, // Index word before the operation.
  input wire [15:0] index_after, // Index word after the operation.
  input wire [15:0] index_word, // Index word for address change.
  input wire [15:0] pc_in, // Program counter.
  input wire load_pc, // Copies the program counter.
  input wire card_count, // Counts the address counter.
  input wire norm_start, // Starts a float normalization.
  input wire [31:0] raw_mant, // Raw float mantissa.
  input wire [7:0] raw_exp, // Raw float exponent.
  output wire busy, // Operation in progress.
  output reg done, // One-cycle completion pulse.
  output reg input_done, // Input order completed pulse.
  output reg branch_reg, // Index branch decision.
  output reg [43:0] command_word_holder, // Held command word.
  output reg [43:0] accumulator, // Accumulator word.
  output reg [15:0] addr_reg, // Address counter.
  output reg [15:0] input_addr, // Designated input address.
  output wire [31:0] norm_mant, // Normalized mantissa.
  output wire [7:0] norm_exp, // Normalized exponent.
  output wire norm_done // Normalization done pulse.
);
  // ----------------------------------------------------------------
  // States and derived tick counts
  // ----------------------------------------------------------------
  localparam [1:0] S_IDLE = 2'b00;
  localparam [1:0] S_WAIT = 2'b01;
  localparam [1:0] S_RUN = 2'b10;

  // Converts microseconds to 5 us ticks, cut on purpose to the counter width.
  function [10:0] to_ticks;
    input integer us;
    integer q;
    begin
      q = us / `TICK_US;
      to_ticks = q[10:0];
    end
  endfunction

  // Tick counts of the timed orders; the largest, 1226, fits in 11 bits.
  localparam [10:0] K_MUL = to_ticks(`T_MUL_BASE_US);
  localparam [10:0] K_REC = to_ticks(`T_RECORD_BASE_US);
  localparam [10:0] K_REC_STEP = to_ticks(`T_RECORD_STEP_US);
  localparam [10:0] K_REC_ZERO = to_ticks(`T_RECORD_ZERO_US);
  localparam [10:0] K_SHL_ONE = to_ticks(`T_SHL_ONE_US);
  localparam [10:0] K_SHL_PAIR = to_ticks(`T_SHL_PAIR_US);
  localparam [10:0] K_SHR = to_ticks(`T_SHR_BASE_US);
  localparam [10:0] K_RND_LO = to_ticks(`T_ROUND_LOW_US);
  localparam [10:0] K_RND_HI = to_ticks(`T_ROUND_HIGH_US);
  localparam [10:0] K_SUB = to_ticks(`T_SUB_PLAIN_US);
  localparam [10:0] K_SUB_DC = to_ticks(`T_SUB_DECOMP_US);
  localparam [10:0] K_ADL = to_ticks(`T_ADDLOC_PLAIN_US);
  localparam [10:0] K_ADL_DC = to_ticks(`T_ADDLOC_DECOMP_US);
  localparam [10:0] K_IDX = to_ticks(`T_INDEX_NOBR_US);
  localparam [10:0] K_IDX_BR = to_ticks(`T_INDEX_BR_US);
  localparam [10:0] K_TAPE = to_ticks(`T_TAPE_SETUP_US);
  localparam [10:0] K_TCTL = to_ticks(`T_TAPE_CTL_US);
  localparam [10:0] K_TXFER = to_ticks(`T_TAPE_XFER_US);
  localparam [10:0] K_DEF = to_ticks(`T_DEFAULT_US);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Weight of one multiplier digit in ticks.
  function [6:0] digit_weight;
    input [3:0] d;
    begin
      case (d)
        4'h0: digit_weight = 7'd1;
        4'h1: digit_weight = 7'd14;
        4'h2: digit_weight = 7'd27;
        4'h3: digit_weight = 7'd40;
        4'h4: digit_weight = 7'd53;
        4'h5: digit_weight = 7'd66;
        4'h6: digit_weight = 7'd65;
        4'h7: digit_weight = 7'd52;
        4'h8: digit_weight = 7'd39;
        4'h9: digit_weight = 7'd26;
        default: digit_weight = 7'd1;
      endcase
    end
  endfunction

  // Converts a two-digit BCD count to binary.
  function [6:0] bcd2_to_bin;
    input [7:0] b;
    begin
      bcd2_to_bin = {3'b000, b[7:4]} * 7'd10 + {3'b000, b[3:0]};
    end
  endfunction

  // Adds two four-digit BCD words, dropping the final carry.
  function [15:0] bcd4_add;
    input [15:0] a;
    input [15:0] b;
    integer i;
    reg [4:0] s;
    reg c;
    begin
      c = 1'b0;
      bcd4_add = 16'h0000;
      for (i = 0; i < 4; i = i + 1) begin
        s = {1'b0, a[4*i +: 4]} + {1'b0, b[4*i +: 4]} + {4'h0, c};
        if (s > 5'd9) begin
          s = s + 5'd6;
          c = 1'b1;
        end else begin
          c = 1'b0;
        end
        bcd4_add[4*i +: 4] = s[3:0];
      end
    end
  endfunction

  // Adds and subtracts share one timing path; only the base differs.
  function [10:0] add_time;
    input [10:0] plain;
    input [10:0] decomped;
    input dc;
    begin
      add_time = dc ? decomped : plain;
    end
  endfunction

  // ----------------------------------------------------------------
  // Command fields and operand decode
  // ----------------------------------------------------------------
  wire [7:0] opc = cmd_word[`CW_OP_HI -: 8];
  wire [3:0] var_digit = cmd_word[`CW_VAR_HI -: 4];
  wire [7:0] count_bcd = cmd_word[`CW_COUNT_HI -: 8];
  wire [6:0] count_bin = bcd2_to_bin(count_bcd);
  wire index_branch = (index_after >= index_before);
  wire is_input_op = (opc == `OPC_INPUT_KEY) || (opc == `OPC_INPUT_TAPE) ||
    (opc == `OPC_INPUT_CARD_A) || (opc == `OPC_INPUT_CARD_B) ||
    (opc == `OPC_INPUT_CARD_C);
  wire is_tape_ctl = (opc == `OPC_TAPE_CTL) || (opc == `OPC_TAPE_XFER);

  // Sum of the multiplier digit weights over all ten positions.
  reg [9:0] weight_sum;
  integer k;
  always @* begin
    weight_sum = 10'd0;
    for (k = 0; k < 10; k = k + 1) begin
      weight_sum = weight_sum + {3'b000, digit_weight(accumulator[4*k +: 4])};
    end
  end

  // Shift counts reduced modulo 10 and 20.
  wire [6:0] count_mod10 = {3'b000, count_bcd[3:0]};
  wire [6:0] count_mod20 = {3'b000, count_bcd[3:0]} + (count_bcd[4] ? 7'd10 : 7'd0);

  // Duration of the current instruction in 5 us ticks.
  reg [10:0] ticks_needed;
  always @* begin
    case (opc)
      `OPC_PRODUCT: ticks_needed = K_MUL + {1'b0, weight_sum};
      `OPC_RECORD_MOVE: begin
        if (count_bin == 7'd0) begin
          ticks_needed = K_REC_ZERO;
        end else begin
          ticks_needed = K_REC + K_REC_STEP * {4'h0, count_bin};
        end
      end
      `OPC_SHL: begin
        if (var_digit == 4'h1) begin
          ticks_needed = K_SHL_PAIR - {4'h0, count_mod20};
        end else begin
          ticks_needed = K_SHL_ONE - {4'h0, count_mod10};
        end
      end
      `OPC_SHR: ticks_needed = K_SHR + {4'h0, count_bin};
      `OPC_ROUND: begin
        if (remainder_word[39:36] < `ROUND_THRESHOLD) begin
          ticks_needed = K_RND_LO;
        end else begin
          ticks_needed = K_RND_HI;
        end
      end
      `OPC_ADD: ticks_needed = add_time(K_SUB, K_SUB_DC, decomp);
      `OPC_SUB: ticks_needed = add_time(K_SUB, K_SUB_DC, decomp);
      `OPC_ADD_LOC: ticks_needed = add_time(K_ADL, K_ADL_DC, decomp);
      `OPC_INC_INDEX_BR: ticks_needed = index_branch ? K_IDX_BR : K_IDX;
      `OPC_DEC_INDEX_BR: ticks_needed = index_branch ? K_IDX_BR : K_IDX;
      `OPC_TAPE_CTL: begin
        if (var_digit < 4'h2) begin
          ticks_needed = K_TCTL;
        end else begin
          ticks_needed = K_TXFER;
        end
      end
      `OPC_TAPE_XFER: ticks_needed = K_TXFER;
      default: begin
        if (opc >= `OPC_TAPE_LO && opc <= `OPC_TAPE_HI) begin
          ticks_needed = K_TAPE;
        end else begin
          ticks_needed = K_DEF;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Duration sequencer
  // ----------------------------------------------------------------
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [10:0] count_reg;
  reg input_op_reg;
  reg restart_tick;
  wire tick;

  tick_divider u_tick (
    .core_clk(core_clk),
    .rst(rst),
    .restart(restart_tick),
    .tick(tick)
  );

  assign busy = (state_reg != S_IDLE);

  // Next-state logic; transfers wait for a ready tape unit.
  always @* begin
    restart_tick = 1'b0;
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (start) begin
          restart_tick = 1'b1;
          if (is_tape_ctl && !tape_ready) begin
            state_next = S_WAIT;
          end else begin
            state_next = S_RUN;
          end
        end
      end
      S_WAIT: begin
        if (tape_ready) begin
          restart_tick = 1'b1;
          state_next = S_RUN;
        end
      end
      S_RUN: begin
        if (tick && count_reg == 11'd1) begin
          state_next = S_IDLE;
        end
      end
      default: state_next = S_IDLE;
    endcase
  end

  // Counts ticks down and pulses done when the count expires.
  always @(posedge core_clk) begin
    if (rst) begin
      state_reg <= S_IDLE;
      count_reg <= 11'd0;
      done <= 1'b0;
      input_done <= 1'b0;
      input_op_reg <= 1'b0;
      branch_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      done <= 1'b0;
      input_done <= 1'b0;
      if (state_reg == S_IDLE && start) begin
        count_reg <= ticks_needed;
        input_op_reg <= is_input_op;
        branch_reg <= index_branch;
      end else if (state_reg == S_RUN && tick) begin
        count_reg <= count_reg - 11'd1;
        if (count_reg == 11'd1) begin
          done <= 1'b1;
          input_done <= input_op_reg;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Register transfers
  // ----------------------------------------------------------------
  // Latches the command word; clear and load (opcode 10) copies the storage word into the accumulator unchanged.
  always @(posedge core_clk) begin
    if (rst) begin
      command_word_holder <= 44'h00000000000;
      accumulator <= 44'h00000000000;
    end else if (start && state_reg == S_IDLE) begin
      command_word_holder <= cmd_word;
      if (opc == `OPC_CLEAR_LOAD) begin
        accumulator <= store_word;
      end
    end
  end

  // Address counter: parallel copy of the program counter, or counting.
  always @(posedge core_clk) begin
    if (rst) begin
      addr_reg <= 16'h0000;
    end else if (load_pc) begin
      addr_reg <= pc_in;
    end else if (card_count) begin
      if (addr_reg == `WORDS_LAST_BCD) begin
        addr_reg <= 16'h0000;
      end else begin
        addr_reg <= bcd4_add(addr_reg, 16'h0001);
      end
    end
  end

  // Designated input address, indexed for variation digits 8 and 9.
  always @(posedge core_clk) begin
    if (rst) begin
      input_addr <= 16'h0000;
    end else if (start && state_reg == S_IDLE && is_input_op) begin
      if (var_digit == 4'h8 || var_digit == 4'h9) begin
        input_addr <= bcd4_add(cmd_word[`CW_ADDR_HI -: 16], index_word);
      end else begin
        input_addr <= cmd_word[`CW_ADDR_HI -: 16];
      end
    end
  end

  // ----------------------------------------------------------------
  // Floating-point normalization
  // ----------------------------------------------------------------
  mantissa_normalizer u_norm (
    .core_clk(core_clk),
    .rst(rst),
    .start(norm_start),
    .mant_in(raw_mant),
    .exp_in(raw_exp),
    .mant_reg(norm_mant),
    .exp_reg(norm_exp),
    .norm_done(norm_done)
  );
endmodule
`default_nettype wire

/* verification/instruction_timing_sequencer_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module timing_seq_checker (
  input wire logic core_clk, // Processor clock.
  input wire logic rst, // Synchronous reset.
  input wire logic start, // Start request.
  input wire logic [43:0] cmd_word, // Instruction word.
  input wire logic [43:0] store_word, // Storage word.
  input wire logic [15:0] index_before, // Index before.
  input wire logic [15:0] index_after, // Index after.
  input wire logic [15:0] pc_in, // Program counter.
  input wire logic load_pc, // Counter copy strobe.
  input wire logic card_count, // Counter step strobe.
  input wire logic busy, // Operation running.
  input wire logic done, // Completion pulse.
  input wire logic input_done, // Input completion pulse.
  input wire logic branch_reg, // Branch decision.
  input wire logic [43:0] command_word_holder, // Held instruction.
  input wire logic [43:0] accumulator, // Accumulator.
  input wire logic [15:0] addr_reg, // Address counter.
  input wire logic [31:0] norm_mant, // Normalized mantissa.
  input wire logic norm_done // Normalization pulse.
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [15:0] run_cnt;
  // Counts the cycles of the running operation.
  always @(posedge core_clk) begin
    if (rst || !busy) run_cnt <= 16'h0000;
    else run_cnt <= run_cnt + 16'h0001;
  end
  // Timing, handshake and register transfer properties.
  property p_done_pulse; done |=> !done; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done wider than one cycle");
  property p_start_busy; start && !busy |=> busy; endproperty
  a_start_busy: assert property (p_start_busy) else $error("accepted start left busy low");
  property p_busy_end; $fell(busy) |-> done; endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy ended without done");
  property p_min_len; done |-> run_cnt > 16'h03de; endproperty
  a_min_len: assert property (p_min_len) else $error("operation shorter than twenty ticks");
  property p_idle; !busy && !start |=> !done; endproperty
  a_idle: assert property (p_idle) else $error("done while idle");
  property p_in_pair; input_done |-> done; endproperty
  a_in_pair: assert property (p_in_pair) else $error("input completion apart from done");
  property p_cw; start && !busy |=> command_word_holder == $past(cmd_word); endproperty
  a_cw: assert property (p_cw) else $error("command word not held whole");
  property p_acc; start && !busy && cmd_word[23:16] == 8'h10 |=> accumulator == $past(store_word); endproperty
  a_acc: assert property (p_acc) else $error("accumulator differs from storage word");
  property p_br;
    start && !busy && cmd_word[23:17] == 7'h10 |=> branch_reg == ($past(index_after) >= $past(index_before));
  endproperty
  a_br: assert property (p_br) else $error("wrong index branch decision");
  property p_pc; load_pc |=> addr_reg == $past(pc_in); endproperty
  a_pc: assert property (p_pc) else $error("program counter copy incomplete");
  property p_wrap; card_count && !load_pc && addr_reg == 16'h5999 |=> addr_reg == 16'h0000; endproperty
  a_wrap: assert property (p_wrap) else $error("address counter did not wrap");
  property p_norm; norm_done |-> norm_mant[31:28] != 4'h0 || norm_mant == 32'h0; endproperty
  a_norm: assert property (p_norm) else $error("mantissa not normalized");
endmodule
bind instruction_timing_sequencer timing_seq_checker chk (.core_clk(core_clk), .rst(rst), .start(start),
  .cmd_word(cmd_word), .store_word(store_word), .index_before(index_before), .index_after(index_after),
  .pc_in(pc_in), .load_pc(load_pc), .card_count(card_count), .busy(busy), .done(done),
  .input_done(input_done), .branch_reg(branch_reg), .command_word_holder(command_word_holder),
  .accumulator(accumulator), .addr_reg(addr_reg), .norm_mant(norm_mant), .norm_done(norm_done));
`default_nettype wire

/* verification/icu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module icu_model (
  input wire logic core_clk, // Processor clock.
  input wire logic done, // Completion pulse.
  input wire logic input_done, // Input completion pulse.
  output logic start, // Start request.
  output logic [43:0] cmd_word, // Instruction word.
  output logic [31:0] cycles, // Length of the last order.
  output logic in_seen // Input completion seen with done.
);
  // Keeps the request lines quiet until an order is issued.
  initial begin
    start = 1'b0;
    cmd_word = 44'h0;
    cycles = 32'h0;
    in_seen = 1'b0;
  end
  // Issues one order and times it until the completion pulse.
  task automatic issue(input logic [43:0] w);
    @(negedge core_clk);
    start = 1'b1;
    cmd_word = w;
    cycles = 32'h0;
    in_seen = 1'b0;
    do begin
      @(negedge core_clk);
      start = 1'b0;
      cycles = cycles + 32'h1;
      if (input_done === 1'b1 && done === 1'b1) in_seen = 1'b1;
    end while (done !== 1'b1 && cycles < 32'h11170);
  endtask
endmodule
`default_nettype wire

/* verification/instruction_timing_sequencer_test.sv */
`timescale 1ns/1ps
`default_nettype none
module instruction_timing_sequencer_test;
  logic core_clk, rst, start, decomp, tape_ready, load_pc, card_count, norm_start;
  logic [43:0] cmd_word, store_word, command_word_holder, accumulator;
  logic [39:0] remainder_word;
  logic [15:0] index_before, index_after, index_word, pc_in, addr_reg, input_addr;
  logic [31:0] raw_mant, norm_mant, cycles;
  logic [7:0] raw_exp, norm_exp;
  logic busy, done, input_done, branch_reg, norm_done, in_seen;
  int fails, comparisons;
  instruction_timing_sequencer dut (.core_clk(core_clk), .rst(rst), .start(start), .cmd_word(cmd_word),
    .store_word(store_word), .remainder_word(remainder_word), .decomp(decomp), .tape_ready(tape_ready),
    .index_before(index_before), .index_after(index_after), .index_word(index_word), .pc_in(pc_in),
    .load_pc(load_pc), .card_count(card_count), .norm_start(norm_start), .raw_mant(raw_mant),
    .raw_exp(raw_exp), .busy(busy), .done(done), .input_done(input_done), .branch_reg(branch_reg),
    .command_word_holder(command_word_holder), .accumulator(accumulator), .addr_reg(addr_reg),
    .input_addr(input_addr), .norm_mant(norm_mant), .norm_exp(norm_exp), .norm_done(norm_done));
  icu_model icu (.core_clk(core_clk), .done(done), .input_done(input_done), .start(start),
    .cmd_word(cmd_word), .cycles(cycles), .in_seen(in_seen));
  // Makes the 10 MHz processor clock.
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Compares one value and counts the outcome.
  task automatic check(input logic [43:0] seen, input logic [43:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Builds an instruction from variation digit, operation code and address.
  function automatic logic [43:0] cw(input logic [3:0] v, input logic [7:0] op, input logic [15:0] a);
    return {16'h0000, v, op, a};
  endfunction
  // Issues one order and compares its length in ticks of 50 cycles.
  task automatic timed(input logic [43:0] w, input logic [43:0] ticks);
    icu.issue(w);
    check(44'((cycles + 32'h19) / 32'h32), ticks);
  endtask
  task automatic t_reset;
    check(44'({busy, done, input_done}), 44'h0);
    check(44'(addr_reg), 44'h0);
    $display("reset test over");
  endtask
  task automatic t_load_mul;
    store_word = 44'h10000098521;
    timed(cw(4'h0, 8'h10, 16'h0000), 44'h14);
    check(accumulator, 44'h10000098521);
    check(command_word_holder, cw(4'h0, 8'h10, 16'h0000));
    timed(cw(4'h0, 8'h14, 16'h0000), 44'hc3);
    $display("multiply test over");
  endtask
  task automatic t_shift;
    timed(cw(4'h0, 8'h49, 16'h0013), 44'h1d);
    timed(cw(4'h1, 8'h49, 16'h0019), 44'h17);
    timed(cw(4'h0, 8'h48, 16'h0005), 44'h1b);
    $display("shift test over");
  endtask
  task automatic t_round_sub;
    remainder_word = 40'h4000000000;
    timed(cw(4'h0, 8'h16, 16'h0000), 44'h15);
    remainder_word = 40'h5000000000;
    timed(cw(4'h0, 8'h16, 16'h0000), 44'h21);
    timed(cw(4'h0, 8'h13, 16'h0000), 44'h25);
    decomp = 1'b1;
    timed(cw(4'h0, 8'h13, 16'h0000), 44'h31);
    decomp = 1'b0;
    timed(cw(4'h0, 8'h19, 16'h0000), 44'h33);
    $display("round and subtract test over");
  endtask
  task automatic t_input;
    index_word = 16'h0456;
    timed(cw(4'h8, 8'h03, 16'h0123), 44'h14);
    check(44'(input_addr), 44'h0579);
    check(44'(in_seen), 44'h1);
    timed(cw(4'h0, 8'h60, 16'h0123), 44'h14);
    check(44'(input_addr), 44'h0123);
    $display("input test over");
  endtask
  task automatic t_branch;
    index_before = 16'h0010;
    index_after = 16'h0010;
    timed(cw(4'h0, 8'h20, 16'h0000), 44'h1e);
    check(44'(branch_reg), 44'h1);
    index_after = 16'h0009;
    timed(cw(4'h0, 8'h21, 16'h0000), 44'h1a);
    check(44'(branch_reg), 44'h0);
    $display("branch test over");
  endtask
  task automatic t_addr;
    pc_in = 16'h5999;
    load_pc = 1'b1;
    @(negedge core_clk);
    load_pc = 1'b0;
    check(44'(addr_reg), 44'h5999);
    card_count = 1'b1;
    @(negedge core_clk);
    check(44'(addr_reg), 44'h0000);
    @(negedge core_clk);
    card_count = 1'b0;
    check(44'(addr_reg), 44'h0001);
    $display("address counter test over");
  endtask
  task automatic t_norm;
    raw_mant = 32'h00012345;
    norm_start = 1'b1;
    @(negedge core_clk);
    norm_start = 1'b0;
    for (int i = 0; i < 20 && norm_done !== 1'b1; i++) @(negedge core_clk);
    check(44'(norm_mant), 44'h12345000);
    check(44'(norm_exp), 44'h0d);
    $display("normalize test over");
  endtask
  task automatic t_tape;
    timed(cw(4'h0, 8'h52, 16'h0000), 44'h20);
    timed(cw(4'h0, 8'h50, 16'h0000), 44'h27);
    tape_ready = 1'b0;
    fork
      icu.issue(cw(4'h0, 8'h51, 16'h0000));
      begin
        repeat (300) @(negedge core_clk);
        tape_ready = 1'b1;
      end
    join
    check(44'((cycles - 32'h113) / 32'h32), 44'h31);
    timed(cw(4'h0, 8'h29, 16'h0001), 44'h26);
    timed(cw(4'h0, 8'h29, 16'h0000), 44'h4ca);
    $display("tape and record move test over");
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Resets the block and runs every scenario in turn.
  initial begin
    {rst, decomp, tape_ready, load_pc, card_count, norm_start} = 6'h28;
    {store_word, remainder_word, index_before, index_after, index_word, pc_in} = 148'h0;
    raw_mant = 32'h0;
    raw_exp = 8'h10;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    t_reset;
    t_load_mul;
    t_shift;
    t_round_sub;
    t_input;
    t_branch;
    t_addr;
    t_norm;
    t_tape;
    tally_and_finish;
  end
  // Cuts a hung run short well after the expected 99000 cycles.
  initial begin
    #11000000;
    fails++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
